// ===== hw/fod_cfg.svh
`ifndef FOD_CFG_SVH
`define FOD_CFG_SVH

// Primary opcode values, bits 31..26
`define FOD_FLOAT_LOAD_WORD_OP      6'h31
`define FOD_FLOAT_STORE_WORD_OP     6'h39
`define FOD_FLOAT_LOAD_DOUBLE_OP    6'h35
`define FOD_FLOAT_STORE_DOUBLE_OP   6'h3d
`define FOD_FLOAT_COPROC_CLASS_OP   6'h11
`define FOD_FLOAT_EXTENDED_CLASS_OP 6'h13
`define FOD_INTEGER_MISC_CLASS_OP   6'h00

// Format field values, bits 25..21
`define FOD_FMT_MOVE_FROM   5'h00
`define FOD_FMT_DMOVE_FROM  5'h01
`define FOD_FMT_CTRL_FROM   5'h02
`define FOD_FMT_MOVE_TO     5'h04
`define FOD_FMT_DMOVE_TO    5'h05
`define FOD_FMT_CTRL_TO     5'h06
`define FOD_BRANCH_SUBCLASS 5'h08
`define FOD_FMT_SINGLE      5'h10
`define FOD_FMT_DOUBLE      5'h11
`define FOD_FMT_WORD        5'h14
`define FOD_FMT_LONG        5'h15

// Function field values and bit positions
`define FOD_FLOAT_CONDMOVE_COL    3'h1
`define FOD_INTEGER_CONDMOVE_GROUP 6'h01
`define FOD_X_PREFETCH_FN         6'h0f
`define FOD_BRANCH_NULLIFY_BIT    17
`define FOD_TRUE_FALSE_BIT        16

// Register offsets and reset values
`define FOD_REG_CTRL   3'h0
`define FOD_REG_INSTR  3'h1
`define FOD_REG_FCC    3'h2
`define FOD_REG_RESULT 3'h3
`define FOD_REG_RSVCNT 3'h4
`define FOD_FCC_RESET  8'h00
`define FOD_RESP_OKAY  2'h0
`define FOD_RESP_SLVERR 2'h2

`endif

// ===== hw/fod_decoder.sv
// Overview of operation
// (RQ1) Opcode first; four load/store opcodes complete
// (RQ2) Three class opcodes need further field decode
// (RQ3) Format field: register moves or subclasses
// (RQ4) Branch identified by nullify and true/false
// (RQ5) Function field identifies formatted operations
// (RQ6) Float conditional move split by true/false
// (RQ7) Extended class decoded from function alone
// (RQ8) Integer conditional move split by true/false
// (RQ9) Function grid: row 5..3, column 2..0
// (RQ10) Row 000 arithmetic; no root at level one
// (RQ11) Level one: column 100 undefined
// (RQ12) Row 001 word conversions from level two
// (RQ13) Row 100 format conversions
// (RQ14) Word format: only convert to single/double
// (RQ15) Row 110 eight quiet compare predicates
// (RQ16) Row 111 eight signalling compare predicates
// (RQ17) Levels cumulative; coprocessor three dropped later
// (RQ18) Level three offers level-two-only mode
// (RQ19) Level four offers level two/three modes
// (RQ20) Nullify bit means likely; zero at level one
// (RQ21) True/false compared with condition code
// (RQ22) Undefined encodings flag reserved instruction
// (RQ23) Outputs operation identifier and operand format
`include "fod_cfg.svh"

module fod_decoder #(
  parameter fod_pkg::fod_lvl_t NATIVE_LEVEL = fod_pkg::FOD_LVL_4
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              issue_valid,
  input  wire logic [31:0]       issue_word,
  output logic                   dec_valid,
  output fod_pkg::fod_dec_t      dec_info,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Address decode shared by write and read paths
  function automatic logic fod_mapped(input logic [31:0] a);
    return (a[31:5] == 27'h0) && (a[4:2] <= `FOD_REG_RSVCNT);
  endfunction : fod_mapped

  // Subset level never exceeds what the core natively supports
  function automatic fod_pkg::fod_lvl_t fod_level(input logic [1:0] m);
    return (m > NATIVE_LEVEL) ? NATIVE_LEVEL : fod_pkg::fod_lvl_t'(m); // [RQ18] [RQ19]
  endfunction : fod_level

  // Function field decode for S, D, W and L formats
  function automatic fod_pkg::fod_dec_t fod_fn_decode(
    input fod_pkg::fod_dec_t  din,
    input logic [31:0]        w,
    input fod_pkg::fod_lvl_t  lv
  );
    fod_pkg::fod_dec_t d;
    logic [2:0]        row;
    logic [2:0]        col;
    d   = din;
    row = w[5:3]; // [RQ9]
    col = w[2:0]; // [RQ9]
    d.op = fod_pkg::FOD_OP_RSVD;
    if (d.fmt == fod_pkg::FOD_FMT_W || d.fmt == fod_pkg::FOD_FMT_L)
    begin
      // Fixed-point sources only convert back to float
      if (row == 3'h4 && col == 3'h0)
        d.op = fod_pkg::FOD_OP_CONVERT_TO_SINGLE; // [RQ14]
      else if (row == 3'h4 && col == 3'h1)
        d.op = fod_pkg::FOD_OP_CONVERT_TO_DOUBLE; // [RQ14]
    end
    else
    begin
      unique case (row)
        3'h0:
        begin
          // Root column only exists from level two
          if (col != 3'h4 || lv >= fod_pkg::FOD_LVL_2)         // [RQ11]
            d.op = fod_pkg::fod_op_t'(6'h10 + {3'h0, col});     // [RQ10]
        end
        3'h1:
        begin
          if (col[2] && lv >= fod_pkg::FOD_LVL_2)
            d.op = fod_pkg::fod_op_t'(6'h18 + {4'h0, col[1:0]}); // [RQ12]
          else if (!col[2] && lv >= fod_pkg::FOD_LVL_3)
            d.op = fod_pkg::fod_op_t'(6'h1c + {4'h0, col[1:0]}); // [RQ17]
        end
        3'h2:
        begin
          // Condition-code moves arrive with level four
          if (col == `FOD_FLOAT_CONDMOVE_COL && lv == fod_pkg::FOD_LVL_4)
            d.op = d.tf ? fod_pkg::FOD_OP_FMOVE_IF_TRUE
                        : fod_pkg::FOD_OP_FMOVE_IF_FALSE;       // [RQ6]
        end
        3'h4:
        begin
          if (col == 3'h0 && d.fmt == fod_pkg::FOD_FMT_D)
            d.op = fod_pkg::FOD_OP_CONVERT_TO_SINGLE; // [RQ13]
          else if (col == 3'h1 && d.fmt == fod_pkg::FOD_FMT_S)
            d.op = fod_pkg::FOD_OP_CONVERT_TO_DOUBLE; // [RQ13]
          else if (col == 3'h4)
            d.op = fod_pkg::FOD_OP_CONVERT_TO_WORD; // [RQ13]
          else if (col == 3'h5 && lv >= fod_pkg::FOD_LVL_3)
            d.op = fod_pkg::FOD_OP_CONVERT_TO_LONG;
        end
        3'h6, 3'h7:
        begin
          // Predicate is column, row 111 adds the signalling bit
          d.pred = w[3:0]; // [RQ15] [RQ16]
          d.cc   = w[10:8];
          if (lv == fod_pkg::FOD_LVL_4 || w[10:8] == 3'h0)
            d.op = fod_pkg::FOD_OP_COMPARE; // [RQ15] [RQ16]
        end
        default:
          d.op = fod_pkg::FOD_OP_RSVD;
      endcase
    end
    return d; // [RQ5]
  endfunction : fod_fn_decode

  // Whole-word decode, purely combinational
  function automatic fod_pkg::fod_dec_t fod_decode(
    input logic [31:0]        w,
    input fod_pkg::fod_lvl_t  lv,
    input logic [7:0]         fcc
  );
    fod_pkg::fod_dec_t d;
    logic [5:0]        opc;
    logic [4:0]        fm;
    logic [5:0]        fn;
    d     = '0;
    opc   = w[31:26];
    fm    = w[25:21];
    fn    = w[5:0];
    d.tf  = w[`FOD_TRUE_FALSE_BIT];
    d.cc  = w[20:18];
    d.op  = fod_pkg::FOD_OP_NONE;
    unique case (opc) // [RQ1]
      `FOD_FLOAT_LOAD_WORD_OP:
        d.op = fod_pkg::FOD_OP_LOAD_WORD; // [RQ1]
      `FOD_FLOAT_STORE_WORD_OP:
        d.op = fod_pkg::FOD_OP_STORE_WORD; // [RQ1]
      `FOD_FLOAT_LOAD_DOUBLE_OP:
        d.op = (lv >= fod_pkg::FOD_LVL_2) ? fod_pkg::FOD_OP_LOAD_DOUBLE
                                          : fod_pkg::FOD_OP_RSVD; // [RQ1]
      `FOD_FLOAT_STORE_DOUBLE_OP:
        d.op = (lv >= fod_pkg::FOD_LVL_2) ? fod_pkg::FOD_OP_STORE_DOUBLE
                                          : fod_pkg::FOD_OP_RSVD; // [RQ1]
      `FOD_FLOAT_COPROC_CLASS_OP:
      begin
        d.op = fod_pkg::FOD_OP_RSVD; // [RQ2]
        unique case (fm) // [RQ3]
          `FOD_FMT_MOVE_FROM: d.op = fod_pkg::FOD_OP_MOVE_FROM;
          `FOD_FMT_CTRL_FROM: d.op = fod_pkg::FOD_OP_CTRL_FROM;
          `FOD_FMT_MOVE_TO:   d.op = fod_pkg::FOD_OP_MOVE_TO;
          `FOD_FMT_CTRL_TO:   d.op = fod_pkg::FOD_OP_CTRL_TO;
          `FOD_FMT_DMOVE_FROM:
            if (lv >= fod_pkg::FOD_LVL_3)
              d.op = fod_pkg::FOD_OP_DMOVE_FROM; // [RQ3]
          `FOD_FMT_DMOVE_TO:
            if (lv >= fod_pkg::FOD_LVL_3)
              d.op = fod_pkg::FOD_OP_DMOVE_TO; // [RQ3]
          `FOD_BRANCH_SUBCLASS:
          begin
            // Likely form needs level two; non-zero cc needs level four
            d.likely = w[`FOD_BRANCH_NULLIFY_BIT];              // [RQ20]
            if ((lv >= fod_pkg::FOD_LVL_2 || !d.likely) &&
                (lv == fod_pkg::FOD_LVL_4 || d.cc == 3'h0))
              d.op = fod_pkg::FOD_OP_BRANCH;                    // [RQ4] [RQ20]
          end
          `FOD_FMT_SINGLE, `FOD_FMT_DOUBLE, `FOD_FMT_WORD, `FOD_FMT_LONG:
          begin
            d.fmt = fm[2] ? (fm[0] ? fod_pkg::FOD_FMT_L : fod_pkg::FOD_FMT_W)
                          : (fm[0] ? fod_pkg::FOD_FMT_D : fod_pkg::FOD_FMT_S);
            if (fm != `FOD_FMT_LONG || lv >= fod_pkg::FOD_LVL_3)
              d = fod_fn_decode(d, w, lv);                      // [RQ5]
          end
          default:
            d.op = fod_pkg::FOD_OP_RSVD;
        endcase
      end
      `FOD_FLOAT_EXTENDED_CLASS_OP:
      begin
        // Same opcode served the old coprocessor three below level three
        if (lv <= fod_pkg::FOD_LVL_2)
          d.op = fod_pkg::FOD_OP_CP3_LEGACY; // [RQ17]
        else if (lv == fod_pkg::FOD_LVL_3)
          d.op = fod_pkg::FOD_OP_RSVD; // [RQ17]
        else if (fn == `FOD_X_PREFETCH_FN)
          d.op = fod_pkg::FOD_OP_X_PREFETCH; // [RQ7]
        else if (fn[5:4] == 2'h0 && fn[3:1] == 3'h0)
        begin
          d.op  = fn[3] ? fod_pkg::FOD_OP_X_STORE : fod_pkg::FOD_OP_X_LOAD;
          d.fmt = fn[0] ? fod_pkg::FOD_FMT_D : fod_pkg::FOD_FMT_W; // [RQ7]
        end
        else if (fn[5:4] == 2'h0 && fn[3:0] == 4'h8)
        begin
          d.op  = fod_pkg::FOD_OP_X_STORE;
          d.fmt = fod_pkg::FOD_FMT_W; // [RQ7]
        end
        else if (fn[5:4] == 2'h0 && fn[3:0] == 4'h9)
        begin
          d.op  = fod_pkg::FOD_OP_X_STORE;
          d.fmt = fod_pkg::FOD_FMT_D; // [RQ7]
        end
        else if (fn[5] && fn[2:1] == 2'h0)
        begin
          d.op  = fod_pkg::fod_op_t'(6'h2c + {4'h0, fn[4:3]});  // [RQ7]
          d.fmt = fn[0] ? fod_pkg::FOD_FMT_D : fod_pkg::FOD_FMT_S;
        end
        else
          d.op = fod_pkg::FOD_OP_RSVD;
      end
      `FOD_INTEGER_MISC_CLASS_OP:
      begin
        // Other function values belong to the integer side
        if (fn == `FOD_INTEGER_CONDMOVE_GROUP)
          d.op = (lv != fod_pkg::FOD_LVL_4) ? fod_pkg::FOD_OP_RSVD :
                 d.tf ? fod_pkg::FOD_OP_IMOVE_IF_TRUE
                      : fod_pkg::FOD_OP_IMOVE_IF_FALSE;         // [RQ8]
      end
      default:
        d.op = fod_pkg::FOD_OP_NONE;
    endcase
    d.rsvd = (d.op == fod_pkg::FOD_OP_RSVD); // [RQ22]
    d.cond = (fcc[d.cc] == d.tf); // [RQ21]
    return d; // [RQ23]
  endfunction : fod_decode

  logic [1:0]        mode_q;
  logic [31:0]       instr_q;
  logic [7:0]        fcc_q;
  logic [15:0]       rsvcnt_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic [31:0]       awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic              dec_valid_q;
  fod_pkg::fod_dec_t dec_q;
  fod_pkg::fod_lvl_t lvl;
  fod_pkg::fod_dec_t issue_dec;
  fod_pkg::fod_dec_t reg_dec;
  logic              wr_go;
  logic [2:0]        wr_idx;

  // Active decode map follows the subset mode
  assign lvl       = fod_level(mode_q);
  assign issue_dec = fod_decode(issue_word, lvl, fcc_q);        // [RQ23]
  assign reg_dec   = fod_decode(instr_q, lvl, fcc_q);
  assign wr_go     = aw_full_q && w_full_q && !bvalid_q;
  assign wr_idx    = awaddr_q[4:2];

  // Issue path result, one cycle behind the word
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      dec_valid_q <= 1'b0;
      dec_q       <= '0;
    end
    else
    begin
      dec_valid_q <= issue_valid;
      if (issue_valid)
        dec_q <= issue_dec;
    end
  end

  assign dec_valid = dec_valid_q;
  assign dec_info  = dec_q;

  // Address and data may arrive in either order
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= 32'h0;
      wdata_q   <= 32'h0;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_full_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_go)
        w_full_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready  = !w_full_q && !bvalid_q;

  // Write response after both halves are in
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `FOD_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= fod_mapped(awaddr_q) ? `FOD_RESP_OKAY : `FOD_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Software registers; byte lanes honoured
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mode_q  <= NATIVE_LEVEL;
      instr_q <= 32'h0;
      fcc_q   <= `FOD_FCC_RESET;
    end
    else if (wr_go && fod_mapped(awaddr_q))
    begin
      if (wr_idx == `FOD_REG_CTRL && wstrb_q[0])
        mode_q <= wdata_q[1:0]; // [RQ18] [RQ19]
      if (wr_idx == `FOD_REG_FCC && wstrb_q[0])
        fcc_q <= wdata_q[7:0];
      if (wr_idx == `FOD_REG_INSTR)
        for (int i = 0; i < 4; i++)
          if (wstrb_q[i])
            instr_q[8*i +: 8] <= wdata_q[8*i +: 8];
    end
  end

  // Reserved counter: a hit in the clearing cycle still counts
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rsvcnt_q <= 16'h0;
    else if (wr_go && fod_mapped(awaddr_q) && wr_idx == `FOD_REG_RSVCNT)
      rsvcnt_q <= {15'h0, issue_valid && issue_dec.rsvd};
    else if (issue_valid && issue_dec.rsvd && rsvcnt_q != 16'hffff)
      rsvcnt_q <= rsvcnt_q + 16'h1; // [RQ22]
  end

  // Read channel; data taken from flops at accept
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rresp_q  <= `FOD_RESP_OKAY;
      rdata_q  <= 32'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= fod_mapped(s_axi_araddr) ? `FOD_RESP_OKAY : `FOD_RESP_SLVERR;
      rdata_q  <= 32'h0;
      if (fod_mapped(s_axi_araddr))
        unique case (s_axi_araddr[4:2])
          `FOD_REG_CTRL:   rdata_q <= {28'h0, lvl, mode_q};
          `FOD_REG_INSTR:  rdata_q <= instr_q;
          `FOD_REG_FCC:    rdata_q <= {24'h0, fcc_q};
          `FOD_REG_RESULT: rdata_q <= {12'h0, reg_dec};
          default:         rdata_q <= {16'h0, rsvcnt_q};
        endcase
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

endmodule : fod_decoder

// ===== hw/fod_pkg.sv
package fod_pkg;

  typedef enum logic [1:0] {
    FOD_LVL_1 = 2'h0, FOD_LVL_2 = 2'h1, FOD_LVL_3 = 2'h2, FOD_LVL_4 = 2'h3
  } fod_lvl_t;

  typedef enum logic [2:0] {
    FOD_FMT_NONE = 3'h0, FOD_FMT_S = 3'h1, FOD_FMT_D = 3'h2,
    FOD_FMT_W = 3'h3, FOD_FMT_L = 3'h4
  } fod_fmt_t;

  typedef enum logic [5:0] {
    FOD_OP_NONE = 6'h00, FOD_OP_RSVD = 6'h01, FOD_OP_CP3_LEGACY = 6'h02,
    FOD_OP_LOAD_WORD = 6'h03, FOD_OP_STORE_WORD = 6'h04,
    FOD_OP_LOAD_DOUBLE = 6'h05, FOD_OP_STORE_DOUBLE = 6'h06,
    FOD_OP_MOVE_FROM = 6'h07, FOD_OP_DMOVE_FROM = 6'h08, FOD_OP_CTRL_FROM = 6'h09,
    FOD_OP_MOVE_TO = 6'h0a, FOD_OP_DMOVE_TO = 6'h0b, FOD_OP_CTRL_TO = 6'h0c,
    FOD_OP_BRANCH = 6'h0d,
    FOD_OP_ADD = 6'h10, FOD_OP_SUB = 6'h11, FOD_OP_MUL = 6'h12, FOD_OP_DIV = 6'h13,
    FOD_OP_SQRT = 6'h14, FOD_OP_ABS = 6'h15, FOD_OP_MOV = 6'h16, FOD_OP_NEG = 6'h17,
    FOD_OP_ROUND_TO_WORD = 6'h18, FOD_OP_TRUNCATE_TO_WORD = 6'h19,
    FOD_OP_CEILING_TO_WORD = 6'h1a, FOD_OP_FLOOR_TO_WORD = 6'h1b,
    FOD_OP_ROUND_TO_LONG = 6'h1c, FOD_OP_TRUNCATE_TO_LONG = 6'h1d,
    FOD_OP_CEILING_TO_LONG = 6'h1e, FOD_OP_FLOOR_TO_LONG = 6'h1f,
    FOD_OP_CONVERT_TO_SINGLE = 6'h20, FOD_OP_CONVERT_TO_DOUBLE = 6'h21,
    FOD_OP_CONVERT_TO_WORD = 6'h22, FOD_OP_CONVERT_TO_LONG = 6'h23,
    FOD_OP_COMPARE = 6'h24,
    FOD_OP_FMOVE_IF_TRUE = 6'h25, FOD_OP_FMOVE_IF_FALSE = 6'h26,
    FOD_OP_IMOVE_IF_TRUE = 6'h27, FOD_OP_IMOVE_IF_FALSE = 6'h28,
    FOD_OP_X_LOAD = 6'h29, FOD_OP_X_STORE = 6'h2a, FOD_OP_X_PREFETCH = 6'h2b,
    FOD_OP_MADD = 6'h2c, FOD_OP_MSUB = 6'h2d, FOD_OP_NMADD = 6'h2e,
    FOD_OP_NMSUB = 6'h2f
  } fod_op_t;

  // Decoded operation, 20 bits
  typedef struct packed {
    fod_op_t    op;
    fod_fmt_t   fmt;
    logic       rsvd;
    logic       likely;
    logic       tf;
    logic [2:0] cc;
    logic [3:0] pred;
    logic       cond;
  } fod_dec_t;

endpackage : fod_pkg

// ===== test/fod_decoder_props.sv
module fod_props (
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic              issue_valid,
  input wire logic [31:0]       issue_word,
  input wire logic              dec_valid,
  input wire fod_pkg::fod_dec_t dec_info,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata
);
  // One clock domain
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic [10:0] hi;
  // Opcode and format bits
  assign hi = issue_word[31:21];

  AST_DV_RISE:
    assert property (issue_valid |=> dec_valid) else $error("no result");
  AST_DV_IDLE:
    assert property (!issue_valid |=> !dec_valid && $stable(dec_info))
    else $error("result moved while idle");
  AST_LOAD_WORD:
    assert property (issue_valid && issue_word[31:26] == 6'h31
      |=> dec_info.op == fod_pkg::FOD_OP_LOAD_WORD) else $error("load word misdecoded");
  AST_STORE_WORD:
    assert property (issue_valid && issue_word[31:26] == 6'h39
      |=> dec_info.op == fod_pkg::FOD_OP_STORE_WORD) else $error("store word misdecoded");
  AST_ROW_ZERO:
    assert property (issue_valid && hi == 11'h230 && issue_word[5:2] == 4'h0
      |=> dec_info.op == 6'h10 + {4'h0, $past(issue_word[1:0])} &&
      dec_info.fmt == fod_pkg::FOD_FMT_S) else $error("row zero wrong");
  AST_COMPARE:
    assert property (issue_valid && hi == 11'h230 && issue_word[5:4] == 2'h3 &&
      issue_word[10:8] == 3'h0 |=> dec_info.op == fod_pkg::FOD_OP_COMPARE &&
      dec_info.pred == $past(issue_word[3:0])) else $error("compare predicate wrong");
  AST_WORD_FMT:
    assert property (issue_valid && hi == 11'h234 && issue_word[5:1] != 5'h10
      |=> dec_info.op == fod_pkg::FOD_OP_RSVD) else $error("bad word function taken");
  AST_MISC:
    assert property (issue_valid && issue_word[31:26] == 6'h00 && issue_word[5:0] != 6'h01
      |=> dec_info.op == fod_pkg::FOD_OP_NONE) else $error("integer function claimed");
  AST_RSVD_FLAG:
    assert property (issue_valid && hi == 11'h234 && issue_word[5:1] != 5'h10
      |=> dec_info.rsvd) else $error("reserved not flagged");
  AST_RD_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_RD_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : fod_props

bind fod_decoder fod_props u_props (.sys_clk, .sys_rst, .issue_valid, .issue_word,
  .dec_valid, .dec_info, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata);

// ===== test/fod_decoder_test.sv
module fod_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              push = 1'b0, issue_valid, dec_valid;
  logic [31:0]       push_w = 32'h0, issue_word;
  fod_pkg::fod_dec_t dec_info;
  logic [31:0]       awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       wq [$];
  fod_pkg::fod_op_t  eq [$];
  int                err_count = 0, n_checks = 0;

  fod_issuer u_issuer (.sys_clk, .sys_rst, .push, .push_w, .issue_valid, .issue_word);
  fod_decoder dut (
    .sys_clk, .sys_rst, .issue_valid, .issue_word, .dec_valid, .dec_info,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // Free-running 100 MHz clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // Address and data together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask : wr

  // Read; rready a cycle late to see the answer held
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    @(posedge sys_clk);
    rready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e);
    check(32'(r), 32'(er));
  endtask : rdchk

  function automatic logic [31:0] cop(input logic [4:0] f, input logic [5:0] fn);
    return {6'h11, f, 15'h0, fn};
  endfunction : cop

  task automatic add(input logic [31:0] w, input fod_pkg::fod_op_t e);
    wq.push_back(w);
    eq.push_back(e);
  endtask : add

  // Back-to-back words, results judged in order
  task automatic run();
    int i = 0;
    int k = 0;
    int n = 0;
    @(posedge sys_clk);
    while (k < eq.size() && n < 300)
    begin
      push   <= (i < wq.size());
      push_w <= (i < wq.size()) ? wq[i] : 32'h0;
      i++;
      @(posedge sys_clk);
      n++;
      if (dec_valid === 1'b1)
      begin
        check(32'(dec_info.op), 32'(eq[k]));
        check(32'(dec_info.rsvd), 32'(eq[k] == fod_pkg::FOD_OP_RSVD));
        k++;
      end
    end
    push <= 1'b0;
    check(32'(k), 32'(eq.size()));
    wq.delete();
    eq.delete();
  endtask : run

  task automatic s_regs();
    rdchk(32'h00, 32'h0f, 2'h0);
    rdchk(32'h08, 32'h00, 2'h0);
    rdchk(32'h10, 32'h00, 2'h0);
    rdchk(32'h20, 32'h00, 2'h2);
    wr(32'h20, 32'h1, 2'h2);
    wr(32'h0c, 32'h1, 2'h0);
  endtask : s_regs

  task automatic s_decode();
    add(32'hc4000000, fod_pkg::FOD_OP_LOAD_WORD);
    add(32'he4000000, fod_pkg::FOD_OP_STORE_WORD);
    add(32'hd4000000, fod_pkg::FOD_OP_LOAD_DOUBLE);
    add(32'hf4000000, fod_pkg::FOD_OP_STORE_DOUBLE);
    for (int c = 0; c < 8; c++)
    begin
      add(cop(5'h10, 6'(c)), fod_pkg::fod_op_t'(6'h10 + 6'(c)));
      add(cop(5'h10, 6'(8 + c)), fod_pkg::fod_op_t'(6'h18 + 6'(c ^ 4)));
    end
    for (int c = 0; c < 16; c++)
      add(cop(5'h11, 6'(48 + c)), fod_pkg::FOD_OP_COMPARE);
    add(cop(5'h10, 6'h21), fod_pkg::FOD_OP_CONVERT_TO_DOUBLE);
    add(cop(5'h10, 6'h24), fod_pkg::FOD_OP_CONVERT_TO_WORD);
    add(cop(5'h11, 6'h20), fod_pkg::FOD_OP_CONVERT_TO_SINGLE);
    add(cop(5'h10, 6'h20), fod_pkg::FOD_OP_RSVD);
    add(cop(5'h14, 6'h20), fod_pkg::FOD_OP_CONVERT_TO_SINGLE);
    add(cop(5'h14, 6'h21), fod_pkg::FOD_OP_CONVERT_TO_DOUBLE);
    add(cop(5'h14, 6'h24), fod_pkg::FOD_OP_RSVD);
    add(32'h45010000, fod_pkg::FOD_OP_BRANCH);
    add(cop(5'h04, 6'h00), fod_pkg::FOD_OP_MOVE_TO);
    add(cop(5'h00, 6'h00), fod_pkg::FOD_OP_MOVE_FROM);
    add(cop(5'h10, 6'h11) | 32'h10000, fod_pkg::FOD_OP_FMOVE_IF_TRUE);
    add(cop(5'h11, 6'h11), fod_pkg::FOD_OP_FMOVE_IF_FALSE);
    add(32'h00010001, fod_pkg::FOD_OP_IMOVE_IF_TRUE);
    add(32'h00000001, fod_pkg::FOD_OP_IMOVE_IF_FALSE);
    add(32'h00000020, fod_pkg::FOD_OP_NONE);
    add(32'h4c000000, fod_pkg::FOD_OP_X_LOAD);
    add(32'h4c000008, fod_pkg::FOD_OP_X_STORE);
    add(32'h4c00000f, fod_pkg::FOD_OP_X_PREFETCH);
    run();
  endtask : s_decode

  task automatic s_levels();
    wr(32'h00, 32'h0, 2'h0);
    rdchk(32'h00, 32'h00, 2'h0);
    add(cop(5'h10, 6'h04), fod_pkg::FOD_OP_RSVD);
    add(cop(5'h10, 6'h05), fod_pkg::FOD_OP_ABS);
    add(cop(5'h10, 6'h0c), fod_pkg::FOD_OP_RSVD);
    add(32'h45030000, fod_pkg::FOD_OP_RSVD);
    add(32'h4c000000, fod_pkg::FOD_OP_CP3_LEGACY);
    run();
    wr(32'h00, 32'h1, 2'h0);
    add(cop(5'h10, 6'h04), fod_pkg::FOD_OP_SQRT);
    add(cop(5'h10, 6'h0f), fod_pkg::FOD_OP_FLOOR_TO_WORD);
    add(cop(5'h10, 6'h08), fod_pkg::FOD_OP_RSVD);
    add(cop(5'h10, 6'h11), fod_pkg::FOD_OP_RSVD);
    run();
    wr(32'h00, 32'h2, 2'h0);
    rdchk(32'h00, 32'h0a, 2'h0);
    add(cop(5'h10, 6'h08), fod_pkg::FOD_OP_ROUND_TO_LONG);
    add(32'h4c000000, fod_pkg::FOD_OP_RSVD);
    run();
    wr(32'h00, 32'h3, 2'h0);
  endtask : s_levels

  task automatic s_result();
    logic [31:0] d;
    logic [1:0]  r;
    wr(32'h08, 32'h01, 2'h0);
    wr(32'h04, 32'h45010000, 2'h0);
    rd(32'h0c, d, r);
    check(32'(d[19:14]), 32'(fod_pkg::FOD_OP_BRANCH));
    check(32'(d[0]), 32'h1);
    wr(32'h04, 32'h45020000, 2'h0);
    rd(32'h0c, d, r);
    check(32'(d[9]), 32'h1);
    check(32'(d[0]), 32'h0);
  endtask : s_result

  task automatic s_rsvcnt();
    wr(32'h10, 32'h0, 2'h0);
    for (int c = 0; c < 3; c++)
      add(cop(5'h14, 6'h00), fod_pkg::FOD_OP_RSVD);
    run();
    rdchk(32'h10, 32'h3, 2'h0);
    wr(32'h10, 32'h0, 2'h0);
    rdchk(32'h10, 32'h0, 2'h0);
  endtask : s_rsvcnt

  // Main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    s_regs();
    s_decode();
    s_levels();
    s_result();
    s_rsvcnt();
    close_out();
  end

  // Hang guard; tests take about 200 cycles
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
endmodule : fod_decoder_test

// ===== test/fod_issuer.sv
module fod_issuer (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        push,
  input  wire logic [31:0] push_w,
  output logic             issue_valid = 1'b0,
  output logic [31:0]      issue_word = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] q [$];
  // One word a cycle; idle word toggles so stale data never looks valid
  always @(posedge sys_clk)
  begin
    if (sys_rst || q.size() == 0)
    begin
      issue_valid <= 1'b0;
      issue_word  <= ~issue_word;
    end
    else
    begin
      issue_valid <= 1'b1;
      issue_word  <= q.pop_front();
    end
    if (push)
      q.push_back(push_w);
  end
endmodule : fod_issuer
